/* pos_dir.sv */
// rotary direction decision for one move
`default_nettype none
module pos_dir
  import pos_pkg::*;
(
  input wire logic [1:0] dir_sel,
  input wire logic signed [31:0] target,
  input wire logic signed [31:0] current,
  input wire logic [31:0] modulo,
  output logic move_positive,
  output logic allow_multi
);
  logic signed [32:0] delta;
  logic [32:0] fwd;

  always_comb begin
    delta = 33'(target) - 33'(current);
    fwd = delta[32] ? 33'(delta) + {1'b0, modulo} : 33'(delta);
    allow_multi = 1'b0;
    case (pos_dir_type'(dir_sel))
      POS_DIR_LIN: begin
        move_positive = !delta[32];
        allow_multi = 1'b1;
      end
      POS_DIR_NEG: move_positive = 1'b0;
      POS_DIR_POS: move_positive = 1'b1;
      POS_DIR_SHORT: move_positive = (fwd < {2'b00, modulo[31:1]});
      default: move_positive = 1'b1;
    endcase
  end
endmodule : pos_dir
`default_nettype wire

/* pos_host.sv */
// host model: object writes and reads, new-setpoint set and clear pulses
`default_nettype none
module pos_host (
  // clock
  input wire logic clk,
  // object access
  output logic wr,
  output logic [15:0] idx,
  output logic [31:0] wdata,
  // controlword bit 4 pulses
  output logic nsp_set,
  output logic nsp_clr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wr = 1'b0;
    idx = 16'h0000;
    wdata = 32'h0000_0000;
    nsp_set = 1'b0;
    nsp_clr = 1'b0;
  end
  ////////////////////////////////////////
  task automatic put(input logic [15:0] i, input logic [31:0] d);
    @(negedge clk);
    wr = 1'b1;
    idx = i;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    // released data is scrambled so a late sample shows up
    wdata = ~d;
  endtask : put
  task automatic get(input logic [15:0] i);
    @(negedge clk);
    idx = i;
    @(negedge clk);
  endtask : get
  task automatic pulse(input logic clr);
    @(negedge clk);
    nsp_set = !clr;
    nsp_clr = clr;
    @(negedge clk);
    nsp_set = 1'b0;
    nsp_clr = 1'b0;
  endtask : pulse
endmodule : pos_host
`default_nettype wire

/* pos_opts.sv */
// positioning options, following error and slip monitor top
`default_nettype none
module pos_opts
  import pos_pkg::*;
#(
  parameter int TW = 32
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // object access
  input wire logic OBJ_WR,
  input wire logic [15:0] OBJ_IDX,
  input wire logic [31:0] OBJ_WDATA,
  output logic [31:0] OBJ_RDATA,
  output logic OBJ_ERR,
  // controlword and mode
  input wire logic CW_NEWSP_SET,
  input wire logic CW_NEWSP_CLR,
  input wire logic CW_RELATIVE,
  input wire logic PP_MODE,
  input wire logic PV_MODE,
  input wire logic SETPOINT_TAKEN,
  input wire logic TARGET_REACHED,
  output logic CW_NEWSP,
  output logic SW_ACK,
  // positions
  input wire logic signed [31:0] TARGET_IN,
  input wire logic signed [31:0] RAMP_POS,
  input wire logic signed [31:0] ACT_POS,
  input wire logic signed [31:0] DEMAND_POS,
  input wire logic [31:0] MODULO,
  output logic signed [31:0] ABS_TARGET,
  output logic MOVE_POSITIVE,
  output logic ALLOW_MULTI_TURN,
  // slip monitor
  input wire logic signed [31:0] ACT_SPEED,
  input wire logic signed [31:0] SET_SPEED,
  input wire logic [TW-1:0] SLIP_TIME,
  input wire logic SLIP_REACTION_SET,
  output logic SW_SLIP,
  output logic SLIP_REACTION,
  output logic ERR_LOG
);
  import pos_pkg::*;

  logic [15:0] options;
  logic signed [31:0] slip_limit;
  logic signed [31:0] tracking_error;
  logic signed [31:0] prev_target;
  logic has_prev;
  logic [1:0] rel_sel;
  logic [1:0] hof_sel;
  logic signed [31:0] base;
  logic slip_flag;
  logic slip_event;
  logic auto_clear;
  logic take;

  ////////////////////////////////////////////////////////////////////////////////
  // object store
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      options <= POS_OPT_RESET;
    end else if (OBJ_WR && OBJ_IDX == POS_IDX_OPTIONS) begin
      options <= OBJ_WDATA[15:0] & POS_OPT_MASK;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      slip_limit <= POS_SLIP_RESET;
    end else if (OBJ_WR && OBJ_IDX == POS_IDX_SLIPLIM) begin
      slip_limit <= OBJ_WDATA;
    end
  end

  // error readout is sampled so the host sees a stable word
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      tracking_error <= '0;
    end else begin
      tracking_error <= DEMAND_POS - ACT_POS;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      OBJ_RDATA <= '0;
      OBJ_ERR <= 1'b0;
    end else begin
      OBJ_ERR <= 1'b0;
      case (OBJ_IDX)
        POS_IDX_OPTIONS: OBJ_RDATA <= {16'h0000, options};
        POS_IDX_TRACKERR: OBJ_RDATA <= tracking_error;
        POS_IDX_SLIPLIM: OBJ_RDATA <= slip_limit;
        default: begin
          OBJ_RDATA <= '0;
          OBJ_ERR <= 1'b1;
        end
      endcase
      if (OBJ_WR && OBJ_IDX == POS_IDX_TRACKERR) begin
        OBJ_ERR <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // relative base selection
  assign rel_sel = options[POS_REL_LSB +: 2];
  assign hof_sel = options[POS_HOF_LSB +: 2];
  assign take = CW_NEWSP && SETPOINT_TAKEN && PP_MODE;

  always_comb begin
    case (pos_base_type'(rel_sel))
      POS_BASE_RAMP: base = RAMP_POS;
      POS_BASE_ACT: base = ACT_POS;
      POS_BASE_PREV: base = has_prev ? prev_target : '0;
      default: base = has_prev ? prev_target : '0;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      prev_target <= '0;
      has_prev <= 1'b0;
      ABS_TARGET <= '0;
    end else if (take) begin
      has_prev <= 1'b1;
      if (CW_RELATIVE) begin
        prev_target <= base + TARGET_IN;
        ABS_TARGET <= base + TARGET_IN;
      end else begin
        prev_target <= TARGET_IN;
        ABS_TARGET <= TARGET_IN;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // new-setpoint handshake
  always_comb begin
    case (pos_hof_type'(hof_sel))
      POS_HOF_ARRIVE: auto_clear = PP_MODE && SW_ACK && TARGET_REACHED;
      POS_HOF_SOON: auto_clear = PP_MODE && SW_ACK;
      default: auto_clear = 1'b0;
    endcase
  end

  // a host set in the same cycle as an auto clear wins
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      CW_NEWSP <= 1'b0;
    end else if (CW_NEWSP_SET) begin
      CW_NEWSP <= 1'b1;
    end else if (CW_NEWSP_CLR || auto_clear) begin
      CW_NEWSP <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      SW_ACK <= 1'b0;
    end else if (take) begin
      SW_ACK <= 1'b1;
    end else if (!CW_NEWSP) begin
      SW_ACK <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // direction and slip
  pos_dir u_dir (
    .dir_sel(options[POS_DIR_LSB +: 2]),
    .target(ABS_TARGET),
    .current(ACT_POS),
    .modulo(MODULO),
    .move_positive(MOVE_POSITIVE),
    .allow_multi(ALLOW_MULTI_TURN)
  );

  pos_slip #(.TW(TW)) u_slip (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .pv_mode(PV_MODE),
    .act_speed(ACT_SPEED),
    .set_speed(SET_SPEED),
    .limit(slip_limit),
    .slip_time(SLIP_TIME),
    .slip_flag(slip_flag),
    .slip_event(slip_event)
  );

  assign SW_SLIP = slip_flag;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      SLIP_REACTION <= 1'b0;
      ERR_LOG <= 1'b0;
    end else begin
      SLIP_REACTION <= slip_event && SLIP_REACTION_SET;
      ERR_LOG <= SLIP_REACTION;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  a_opt_reset: assert property (@(posedge CORE_CLK)
    SYS_RST |=> options == POS_OPT_RESET && slip_limit == POS_SLIP_RESET) else $error("bad reset value");
  a_ack_drop: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (!CW_NEWSP && !take) |=> !SW_ACK) else $error("ack held after release");
  a_soon_clear: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (hof_sel == 2'b10 && PP_MODE && SW_ACK && !CW_NEWSP_SET) |=> !CW_NEWSP) else $error("no early release");
  a_host_keep: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (hof_sel == 2'b00 && CW_NEWSP && !CW_NEWSP_CLR) |=> CW_NEWSP) else $error("host bit dropped");
  a_rel_act: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (take && CW_RELATIVE && rel_sel == 2'b10) |=> ABS_TARGET == $past(ACT_POS) + $past(TARGET_IN))
    else $error("relative base wrong");
  a_err_log: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    SLIP_REACTION |=> ERR_LOG) else $error("error entry missing");
endmodule : pos_opts
`default_nettype wire

/* pos_opts_tb_top.sv */
// self-checking bench for the positioning options and slip monitor
`default_nettype none
module pos_opts_tb_top
  import pos_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {string nm; int sel; logic [31:0] exp;} pos_note_type;
  pos_note_type notes[$];
  event look;
  integer seed = 32'h0000_d53c;
  int err_total = 0;
  int checks = 0;
  int cycles = 0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rel = 1'b0, pp = 1'b1, pv = 1'b0, taken = 1'b0, reached = 1'b0;
  logic signed [31:0] tgt = '0, ramp = '0, act = '0, dem = '0, aspd = '0, sspd = '0, prev;
  logic wr, nset, nclr, oerr, newsp, ack, movp, multi, slip, react, elog;
  logic [15:0] idx;
  logic [31:0] wdata, rdata, abst, d;
  logic [31:0] modulo = 32'h0000_0168, stime = 32'h0000_0003;
  logic rset = 1'b1;
  int pts[3] = '{50, 250, 300};
  ////////////////////////////////////////
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      stop_test();
    end
  end
  pos_host pos_host_i (.clk(clk), .wr(wr), .idx(idx), .wdata(wdata), .nsp_set(nset), .nsp_clr(nclr));
  pos_opts #(.TW(32)) pos_opts_i (.CORE_CLK(clk), .SYS_RST(rst), .OBJ_WR(wr), .OBJ_IDX(idx),
    .OBJ_WDATA(wdata), .OBJ_RDATA(rdata), .OBJ_ERR(oerr), .CW_NEWSP_SET(nset), .CW_NEWSP_CLR(nclr),
    .CW_RELATIVE(rel), .PP_MODE(pp), .PV_MODE(pv), .SETPOINT_TAKEN(taken), .TARGET_REACHED(reached),
    .CW_NEWSP(newsp), .SW_ACK(ack), .TARGET_IN(tgt), .RAMP_POS(ramp), .ACT_POS(act), .DEMAND_POS(dem),
    .MODULO(modulo), .ABS_TARGET(abst), .MOVE_POSITIVE(movp), .ALLOW_MULTI_TURN(multi),
    .ACT_SPEED(aspd), .SET_SPEED(sspd), .SLIP_TIME(stime), .SLIP_REACTION_SET(rset),
    .SW_SLIP(slip), .SLIP_REACTION(react), .ERR_LOG(elog));
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic note(input string nm, input int sel, input logic [31:0] exp);
    notes.push_back('{nm, sel, exp});
    -> look;
    // let the watcher sample before any input moves
    #1;
  endtask : note
  // watcher: oldest note against the output it names
  always @(look) begin
    pos_note_type n;
    logic [31:0] v [10];
    n = notes.pop_front();
    v = '{rdata, 32'(oerr), 32'(newsp), 32'(ack), abst, 32'(movp), 32'(multi), 32'(slip), 32'(react), 32'(elog)};
    check(n.nm, v[n.sel], n.exp);
  end
  task automatic move();
    pos_host_i.pulse(1'b1);
    pos_host_i.pulse(1'b0);
    taken = 1'b1;
    @(negedge clk);
    taken = 1'b0;
  endtask : move
  function automatic logic signed [31:0] rnd();
    return $random(seed) & 32'h0000_ffff;
  endfunction : rnd
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    pos_host_i.get(POS_IDX_OPTIONS);
    note("options", 0, {16'h0000, POS_OPT_RESET});
    pos_host_i.get(POS_IDX_SLIPLIM);
    note("limit", 0, POS_SLIP_RESET);
    pos_host_i.get(POS_IDX_TRACKERR);
    note("trackerr", 0, 32'h0000_0000);
    pos_host_i.put(POS_IDX_OPTIONS, 32'hffff_ffff);
    pos_host_i.get(POS_IDX_OPTIONS);
    note("options", 0, {16'h0000, POS_OPT_MASK});
    pos_host_i.put(POS_IDX_TRACKERR, 32'h0000_0001);
    note("ro_err", 1, 32'h0000_0001);
    pos_host_i.get(16'h60f3);
    note("idx_err", 1, 32'h0000_0001);
    dem = rnd();
    act = rnd();
    pos_host_i.get(POS_IDX_TRACKERR);
    note("trackerr", 0, dem - act);
    d = $random(seed);
    pos_host_i.put(POS_IDX_SLIPLIM, d);
    pos_host_i.get(POS_IDX_SLIPLIM);
    note("limit", 0, d);
    pos_host_i.put(POS_IDX_SLIPLIM, POS_SLIP_RESET);
    for (int c = 0; c < 4; c++) begin
      pos_host_i.put(POS_IDX_OPTIONS, 32'(c));
      rel = 1'b0;
      tgt = rnd();
      prev = tgt;
      move();
      note("absolute", 4, prev);
      rel = 1'b1;
      tgt = rnd();
      ramp = rnd();
      act = rnd();
      move();
      note("relative", 4, tgt + (c == 1 ? ramp : c == 2 ? act : prev));
    end
    for (int c = 0; c < 4; c++) begin
      pos_host_i.put(POS_IDX_OPTIONS, 32'(c << 4));
      move();
      note("ack", 3, 32'h0000_0001);
      reached = 1'b1;
      repeat (3) @(negedge clk);
      note("newsp", 2, 32'(c % 3 == 0));
      note("ack", 3, 32'(c % 3 == 0));
      reached = 1'b0;
    end
    rel = 1'b0;
    tgt = 32'h0000_0064;
    move();
    for (int c = 0; c < 4; c++) begin
      pos_host_i.put(POS_IDX_OPTIONS, 32'(c << 6));
      foreach (pts[k]) begin
        act = pts[k];
        #10;
        note("dir", 5, 32'(c == 0 ? 100 >= pts[k] : c == 2 | (c == 3 && ((100 - pts[k]) % 360 + 360) % 360 < 180)));
        note("multi", 6, 32'(c == 0));
      end
    end
    pv = 1'b1;
    sspd = 32'h0000_03e8;
    aspd = 32'h0000_0578;
    repeat (8) @(negedge clk);
    note("slip", 7, 32'h0000_0000);
    aspd = 32'h0000_0257;
    repeat (2) @(negedge clk);
    note("slip", 7, 32'h0000_0000);
    for (int n = 0; n < 10 && react !== 1'b1; n++) @(negedge clk);
    note("react", 8, 32'h0000_0001);
    @(negedge clk);
    note("log", 9, 32'h0000_0001);
    note("slip", 7, 32'h0000_0001);
    pos_host_i.put(POS_IDX_SLIPLIM, POS_SLIP_OFF);
    repeat (8) @(negedge clk);
    note("slip", 7, 32'h0000_0000);
    // monitor back on with no reaction configured: flag rises, no reaction pulse
    rset = 1'b0;
    pos_host_i.put(POS_IDX_SLIPLIM, POS_SLIP_RESET);
    repeat (8) @(negedge clk);
    note("slip", 7, 32'h0000_0001);
    note("react", 8, 32'h0000_0000);
    stop_test();
  end
endmodule : pos_opts_tb_top
`default_nettype wire

/* pos_pkg.sv */
// shared constants for the positioning options and slip monitor block
`default_nettype none
package pos_pkg;
  localparam logic [15:0] POS_IDX_OPTIONS = 16'h60F2;
  localparam logic [15:0] POS_IDX_TRACKERR = 16'h60F4;
  localparam logic [15:0] POS_IDX_SLIPLIM = 16'h60F8;
  localparam logic [15:0] POS_OPT_RESET = 16'h0001;
  localparam logic [31:0] POS_SLIP_RESET = 32'h0000_0190;
  localparam logic [31:0] POS_SLIP_OFF = 32'h7FFF_FFFF;
  localparam logic [15:0] POS_OPT_MASK = 16'h00FF;
  localparam int POS_REL_LSB = 0;
  localparam int POS_HOF_LSB = 4;
  localparam int POS_DIR_LSB = 6;
  localparam int POS_CW_NEWSP = 4;
  localparam int POS_CW_REL = 6;
  localparam int POS_SW_ACK = 12;
  localparam int POS_SW_SLIP = 13;
  typedef enum logic [1:0] {POS_BASE_PREV, POS_BASE_RAMP, POS_BASE_ACT, POS_BASE_RSV} pos_base_type;
  typedef enum logic [1:0] {POS_HOF_HOST, POS_HOF_ARRIVE, POS_HOF_SOON, POS_HOF_RSV} pos_hof_type;
  typedef enum logic [1:0] {POS_DIR_LIN, POS_DIR_NEG, POS_DIR_POS, POS_DIR_SHORT} pos_dir_type;
endpackage : pos_pkg
`default_nettype wire

/* pos_slip.sv */
// slippage monitor: persistence timer and flag
`default_nettype none
module pos_slip
  import pos_pkg::*;
#(
  parameter int TW = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // speeds and settings
  input wire logic pv_mode,
  input wire logic signed [31:0] act_speed,
  input wire logic signed [31:0] set_speed,
  input wire logic signed [31:0] limit,
  input wire logic [TW-1:0] slip_time,
  // result
  output logic slip_flag,
  output logic slip_event
);
  logic [TW-1:0] cnt;
  logic signed [32:0] diff;
  logic [32:0] mag;
  logic [32:0] lim_mag;
  logic excess;
  logic enabled;

  always_comb begin
    diff = 33'(act_speed) - 33'(set_speed);
    mag = diff[32] ? 33'(-diff) : 33'(diff);
    lim_mag = limit[31] ? 33'(-33'(limit)) : {1'b0, limit};
    enabled = pv_mode && (limit != POS_SLIP_OFF);
    excess = enabled && (mag > lim_mag);
  end

  // counter saturates so a long excess never wraps back below the time
  always_ff @(posedge clk) begin
    if (rst || !excess) begin
      cnt <= '0;
    end else if (cnt != '1) begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !excess) begin
      slip_flag <= 1'b0;
    end else if (cnt >= slip_time) begin
      slip_flag <= 1'b1;
    end
  end

  assign slip_event = excess && (cnt >= slip_time) && !slip_flag;

  a_slip_off: assert property (@(posedge clk) disable iff (rst)
    (limit == POS_SLIP_OFF) |=> !slip_flag) else $error("slip flag with monitor off");
  a_slip_wait: assert property (@(posedge clk) disable iff (rst)
    $rose(slip_flag) |-> $past(excess) && ($past(cnt) >= $past(slip_time))) else $error("slip flag early");
endmodule : pos_slip
`default_nettype wire
